// *** logic/cala_pkg.sv ***
// constants, field layouts and carriers for the conditional alu add block
// assumes a 24-bit instruction word and 16-bit data registers by default
package cala_pkg;

   // instruction word fields
   localparam int unsigned TYPE_HI = 23;
   localparam int unsigned TYPE_LO = 19;
   localparam int unsigned DEST_BIT = 18;
   localparam int unsigned FUNC_HI = 17;
   localparam int unsigned FUNC_LO = 13;
   localparam int unsigned YOP_HI = 12;
   localparam int unsigned YOP_LO = 11;
   localparam int unsigned XOP_HI = 10;
   localparam int unsigned XOP_LO = 8;
   localparam int unsigned ZERO_HI = 7;
   localparam int unsigned ZERO_LO = 4;
   localparam int unsigned COND_HI = 3;
   localparam int unsigned COND_LO = 0;

   localparam logic [4:0] TYPE_COND_ALU = 5'h04;
   localparam logic [3:0] PAD_ZERO = 4'h0;
   localparam logic [4:0] FUNC_ADD_CARRY = 5'h12;
   localparam logic [4:0] FUNC_ADD = 5'h13;

   // y operand codes; the last one forces zero for the operand-plus-carry form
   localparam logic [1:0] YOP_Y0 = 2'h0;
   localparam logic [1:0] YOP_Y1 = 2'h1;
   localparam logic [1:0] YOP_FB = 2'h2;
   localparam logic [1:0] YOP_ZERO = 2'h3;

   // register indices on the plain port; x operand codes equal indices 0..7
   localparam logic [3:0] REG_X0 = 4'h0;
   localparam logic [3:0] REG_X1 = 4'h1;
   localparam logic [3:0] REG_RESULT = 4'h2;
   localparam logic [3:0] REG_MR0 = 4'h3;
   localparam logic [3:0] REG_MR1 = 4'h4;
   localparam logic [3:0] REG_MR2 = 4'h5;
   localparam logic [3:0] REG_SR0 = 4'h6;
   localparam logic [3:0] REG_SR1 = 4'h7;
   localparam logic [3:0] REG_Y0 = 4'h8;
   localparam logic [3:0] REG_Y1 = 4'h9;
   localparam logic [3:0] REG_FB = 4'hA;
   localparam logic [3:0] REG_STATUS = 4'hB;
   localparam int unsigned NUM_DATA_REGS = 11;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   // status word bit positions
   localparam int unsigned ST_ZERO = 0;
   localparam int unsigned ST_NEG = 1;
   localparam int unsigned ST_OVF = 2;
   localparam int unsigned ST_CARRY = 3;
   localparam int unsigned ST_MAC_OVF = 6;

   // condition codes
   localparam logic [3:0] CC_EQ = 4'h0;
   localparam logic [3:0] CC_NE = 4'h1;
   localparam logic [3:0] CC_GT = 4'h2;
   localparam logic [3:0] CC_LE = 4'h3;
   localparam logic [3:0] CC_LT = 4'h4;
   localparam logic [3:0] CC_GE = 4'h5;
   localparam logic [3:0] CC_OVF = 4'h6;
   localparam logic [3:0] CC_NOT_OVF = 4'h7;
   localparam logic [3:0] CC_CARRY = 4'h8;
   localparam logic [3:0] CC_NOT_CARRY = 4'h9;
   localparam logic [3:0] CC_NEG = 4'hA;
   localparam logic [3:0] CC_POS = 4'hB;
   localparam logic [3:0] CC_MAC_OVF = 4'hC;
   localparam logic [3:0] CC_NOT_MAC_OVF = 4'hD;
   localparam logic [3:0] CC_NOT_CE = 4'hE;
   localparam logic [3:0] CC_ALWAYS = 4'hF;

   // decoded instruction fields
   typedef struct packed {
      logic [4:0] kind;
      logic       dest_fb;
      logic [4:0] func;
      logic [1:0] yop;
      logic [2:0] xop;
      logic [3:0] pad;
      logic [3:0] cond;
   } cala_instr_s;

endpackage

// *** logic/cala_core.sv ***
// conditional alu add / add with carry with its operand registers and status word
// assumes one clock, a sequencer presenting one instruction per strobe, and a
// plain register port driven from the same clock
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
module cala_core #(
   parameter int unsigned DW = 16
) (
   // clock, reset, enable
   input  wire logic          clk_i,
   input  wire logic          rst_b_i,
   input  wire logic          en_i,
   // instruction from the sequencer
   input  wire logic          instr_valid_i,
   input  wire logic [23:0]   instr_i,
   input  wire logic          ce_expired_i,
   // register port
   input  wire logic [3:0]    reg_addr_i,
   input  wire logic [DW-1:0] reg_wdata_i,
   input  wire logic          reg_we_i,
   input  wire logic          reg_re_i,
   output logic      [DW-1:0] reg_rdata_o,
   // results
   output logic               done_o,
   output logic               executed_o,
   output logic      [DW-1:0] result_o,
   output logic      [DW-1:0] feedback_o,
   output logic      [7:0]    status_o
);

   // reset release through two flip-flops
   logic rst_s1_q;
   logic rst_n_q;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_s1_q <= 1'b0;
         rst_n_q  <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q  <= rst_s1_q;
      end
   end

   // condition evaluation against the status word
   function automatic logic cond_true(input logic [3:0] cc, input logic [7:0] st, input logic ce);
      logic z;
      logic n;
      logic v;
      logic c;
      logic m;
      logic r;
      z = st[cala_pkg::ST_ZERO];
      n = st[cala_pkg::ST_NEG];
      v = st[cala_pkg::ST_OVF];
      c = st[cala_pkg::ST_CARRY];
      m = st[cala_pkg::ST_MAC_OVF];
      case (cc)
         cala_pkg::CC_EQ:          r = z;
         cala_pkg::CC_NE:          r = !z;
         cala_pkg::CC_GT:          r = !(n ^ v) && !z;
         cala_pkg::CC_LE:          r = (n ^ v) || z;
         cala_pkg::CC_LT:          r = n ^ v;
         cala_pkg::CC_GE:          r = !(n ^ v);
         cala_pkg::CC_OVF:         r = v;
         cala_pkg::CC_NOT_OVF:     r = !v;
         cala_pkg::CC_CARRY:       r = c;
         cala_pkg::CC_NOT_CARRY:   r = !c;
         cala_pkg::CC_NEG:         r = n;
         cala_pkg::CC_POS:         r = !n;
         cala_pkg::CC_MAC_OVF:     r = m;
         cala_pkg::CC_NOT_MAC_OVF: r = !m;
         cala_pkg::CC_NOT_CE:      r = !ce;
         default:                  r = 1'b1;
      endcase
      return r;
   endfunction

   // state
   logic [DW-1:0] regs_q [cala_pkg::NUM_DATA_REGS];
   logic [DW-1:0] regs_d [cala_pkg::NUM_DATA_REGS];
   logic [7:0]    status_q;
   logic [7:0]    status_d;
   logic [DW-1:0] rdata_q;
   logic [DW-1:0] rdata_d;
   logic          done_q;
   logic          done_d;
   logic          exec_q;
   logic          exec_d;

   // decode and datapath
   cala_pkg::cala_instr_s ins;
   logic          is_type;
   logic          is_add;
   logic          use_carry;
   logic          fire;
   logic [DW-1:0] x_op;
   logic [DW-1:0] y_op;
   logic [DW:0]   sum_ext;
   logic [DW-1:0] sum;
   logic          carry_out;
   logic          ovf;

   assign ins = cala_pkg::cala_instr_s'(instr_i);
   assign is_type = (ins.kind == cala_pkg::TYPE_COND_ALU) && (ins.pad == cala_pkg::PAD_ZERO);
   assign is_add = (ins.func == cala_pkg::FUNC_ADD_CARRY) || (ins.func == cala_pkg::FUNC_ADD);
   assign use_carry = (ins.func == cala_pkg::FUNC_ADD_CARRY) && status_q[cala_pkg::ST_CARRY];
   assign fire = en_i && instr_valid_i && is_type && is_add && cond_true(ins.cond, status_q, ce_expired_i);

   // operand selection, x codes map onto register indices
   always_comb begin
      x_op = regs_q[ins.xop];
      case (ins.yop)
         cala_pkg::YOP_Y0: y_op = regs_q[cala_pkg::REG_Y0];
         cala_pkg::YOP_Y1: y_op = regs_q[cala_pkg::REG_Y1];
         cala_pkg::YOP_FB: y_op = regs_q[cala_pkg::REG_FB];
         default:          y_op = '0;
      endcase
   end

   // binary sum with carry-in and flag terms
   assign sum_ext   = {1'b0, x_op} + {1'b0, y_op} + {{DW{1'b0}}, use_carry};
   assign sum       = sum_ext[DW-1:0];
   assign carry_out = sum_ext[DW];
   assign ovf       = (x_op[DW-1] == y_op[DW-1]) && (sum[DW-1] != x_op[DW-1]);

   // next state: bus writes first, an executing add wins on its own targets
   always_comb begin
      regs_d   = regs_q;
      status_d = status_q;
      rdata_d  = rdata_q;
      done_d   = done_q;
      exec_d   = exec_q;
      if (en_i) begin
         done_d  = instr_valid_i;
         exec_d  = fire;
         rdata_d = '0;
         if (reg_re_i) begin
            if (reg_addr_i < cala_pkg::REG_STATUS) begin
               rdata_d = regs_q[reg_addr_i];
            end else if (reg_addr_i == cala_pkg::REG_STATUS) begin
               rdata_d = DW'(status_q);
            end
         end
         if (reg_we_i) begin
            if (reg_addr_i < cala_pkg::REG_STATUS) begin
               regs_d[reg_addr_i] = reg_wdata_i;
            end else if (reg_addr_i == cala_pkg::REG_STATUS) begin
               status_d = reg_wdata_i[7:0];
            end
         end
         if (fire) begin
            if (ins.dest_fb) begin
               regs_d[cala_pkg::REG_FB] = sum;
            end else begin
               regs_d[cala_pkg::REG_RESULT] = sum;
            end
            status_d = status_q;
            status_d[cala_pkg::ST_ZERO]  = (sum == '0);
            status_d[cala_pkg::ST_NEG]   = sum[DW-1];
            status_d[cala_pkg::ST_OVF]   = ovf;
            status_d[cala_pkg::ST_CARRY] = carry_out;
         end
      end
   end

   // registers
   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         for (int i = 0; i < cala_pkg::NUM_DATA_REGS; i++) begin
            regs_q[i] <= '0;
         end
         status_q <= cala_pkg::STATUS_RESET;
         rdata_q  <= '0;
         done_q   <= 1'b0;
         exec_q   <= 1'b0;
      end else begin
         regs_q   <= regs_d;
         status_q <= status_d;
         rdata_q  <= rdata_d;
         done_q   <= done_d;
         exec_q   <= exec_d;
      end
   end

   // outputs straight from flip-flops
   assign reg_rdata_o = rdata_q;
   assign done_o      = done_q;
   assign executed_o  = exec_q;
   assign result_o    = regs_q[cala_pkg::REG_RESULT];
   assign feedback_o  = regs_q[cala_pkg::REG_FB];
   assign status_o    = status_q;

   // checks
   logic no_bus_wr;
   assign no_bus_wr = !reg_we_i;

   sequence add_to_result_s;
      fire && !ins.dest_fb && no_bus_wr;
   endsequence

   sequence add_to_fb_s;
      fire && ins.dest_fb && no_bus_wr;
   endsequence

   // operand-plus-carry form aimed at the result register
   sequence carry_only_s;
      fire && !ins.dest_fb && no_bus_wr && (ins.yop == cala_pkg::YOP_ZERO)
         && (ins.func == cala_pkg::FUNC_ADD_CARRY);
   endsequence

   cond_false_nop_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      (en_i && instr_valid_i && is_type && is_add && !fire && no_bus_wr) |=> $stable(status_q) && !exec_q
         && $stable(regs_q[cala_pkg::REG_RESULT]) && $stable(regs_q[cala_pkg::REG_FB]))
      else $error("false condition changed state");

   result_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      add_to_result_s |=> (result_o == $past(sum)) && $stable(regs_q[cala_pkg::REG_FB]))
      else $error("result register not written by add");

   fb_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      add_to_fb_s |=> (feedback_o == $past(sum)) && $stable(regs_q[cala_pkg::REG_RESULT]))
      else $error("feedback register not written by add");

   carry_sum_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      fire |-> sum_ext == ({1'b0, x_op} + {1'b0, y_op}
         + ((ins.func == cala_pkg::FUNC_ADD_CARRY) ? status_q[cala_pkg::ST_CARRY] : 1'b0)))
      else $error("sum does not match operands and carry");

   zero_y_form_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      carry_only_s
         |=> result_o == $past(x_op) + DW'($past(status_q[cala_pkg::ST_CARRY])))
      else $error("operand plus carry form wrong");

   zn_flags_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      (fire && no_bus_wr) |=> (status_q[cala_pkg::ST_ZERO] == ($past(sum) == '0))
         && (status_q[cala_pkg::ST_NEG] == $past(sum[DW-1])))
      else $error("zero or negative flag wrong");

   ovf_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      (fire && no_bus_wr) |=> status_q[cala_pkg::ST_OVF] == ($past(x_op[DW-1]) == $past(y_op[DW-1])
         && $past(sum[DW-1]) != $past(x_op[DW-1])))
      else $error("overflow flag wrong");

   carry_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      (fire && no_bus_wr) |=> status_q[cala_pkg::ST_CARRY] == $past(sum_ext[DW]))
      else $error("carry flag wrong");

   upper_bits_kept_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      (fire && no_bus_wr) |=> status_q[7:4] == $past(status_q[7:4]))
      else $error("untouched status bits changed");

   bad_type_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      (en_i && instr_valid_i && (instr_i[cala_pkg::ZERO_HI:cala_pkg::ZERO_LO] != cala_pkg::PAD_ZERO))
         |=> done_q && !exec_q)
      else $error("malformed word executed");

   one_cycle_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      fire ##1 en_i |-> done_q && exec_q ##1 !exec_q || $past(fire))
      else $error("add not completed in one cycle");

   always_add_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      (en_i && instr_valid_i && is_type && is_add && (ins.cond == cala_pkg::CC_ALWAYS)) |-> fire)
      else $error("unconditional add did not execute");

   other_func_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      (en_i && instr_valid_i && is_type && !is_add && no_bus_wr) |=> !exec_q && $stable(status_q)
         && $stable(regs_q[cala_pkg::REG_RESULT]) && $stable(regs_q[cala_pkg::REG_FB]))
      else $error("other function changed state");

   enable_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      !en_i |=> $stable(status_q) && $stable(done_q) && $stable(exec_q) && $stable(rdata_q)
         && $stable(regs_q[cala_pkg::REG_RESULT]) && $stable(regs_q[cala_pkg::REG_FB]))
      else $error("state moved while enable low");

   status_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      (en_i && reg_re_i && (reg_addr_i == cala_pkg::REG_STATUS)) |=> reg_rdata_o == DW'($past(status_q)))
      else $error("status read data wrong");

   read_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      (en_i && !reg_re_i) |=> reg_rdata_o == '0)
      else $error("read data left standing");

   bus_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
      (en_i && reg_we_i && (reg_addr_i == cala_pkg::REG_Y0)) |=> regs_q[cala_pkg::REG_Y0] == $past(reg_wdata_i))
      else $error("bus write did not land");

endmodule

// *** verif/cala_seq_model.sv ***
// instruction sequencer model feeding the conditional alu add block
// assumes tasks are called just after a rising clock edge
`timescale 1ns/10ps
module cala_seq_model (
   // clock
   input  wire logic        clk_i,
   // instruction issue
   output logic             instr_valid_o,
   output logic [23:0]      instr_o
);
   // nothing issued at start
   initial begin
      instr_valid_o = 1'b0;
      instr_o = 24'h000000;
   end

   // one word per clock; valid stays up for back-to-back issue
   task automatic send(input logic [23:0] w);
      instr_valid_o <= 1'b1;
      instr_o <= w;
      @(posedge clk_i);
   endtask

   // released word bus shows the inverse of the last word, not a stale copy
   task automatic idle();
      instr_valid_o <= 1'b0;
      instr_o <= ~instr_o;
      // one idle edge, so the next issue never re-drives valid in this step
      @(posedge clk_i);
      #1;
   endtask
endmodule

// *** verif/tb_conditional_alu_add.sv ***
// self-checking bench for the conditional alu add core
// assumes the core with its default 16-bit width and one 40 MHz clock
`timescale 1ns/10ps
module tb_conditional_alu_add;
   logic        clk_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic        en_i = 1'b1;
   logic        ce_expired_i = 1'b0;
   logic [3:0]  reg_addr_i = 4'h0;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic        reg_we_i = 1'b0;
   logic        reg_re_i = 1'b0;
   logic        instr_valid_i;
   logic [23:0] instr_i;
   logic [15:0] reg_rdata_o, result_o, feedback_o;
   logic        done_o, executed_o;
   logic [7:0]  status_o;
   logic [15:0] regs [0:10];
   logic [7:0]  st;
   int          failures = 0;
   int          total_checks = 0;
   int          i;
   bit          gap;
   bit          do_wr;
   bit          do_rd;

   // 25 ns clock
   always #12.5 clk_i = ~clk_i;

   cala_core cala_core_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .en_i(en_i), .instr_valid_i(instr_valid_i),
      .instr_i(instr_i), .ce_expired_i(ce_expired_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .done_o(done_o),
      .executed_o(executed_o), .result_o(result_o), .feedback_o(feedback_o), .status_o(status_o));

   cala_seq_model cala_seq_model_i (.clk_i(clk_i), .instr_valid_o(instr_valid_i), .instr_o(instr_i));

   // verdict and end of run
   task automatic final_report();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // one comparison
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // bus write, mirror follows; indices above status are ignored
   // strobe stays up until the next request or issue lowers it
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_we_i <= 1'b1;
      reg_re_i <= 1'b0;
      @(posedge clk_i);
      #1;
      if (a < cala_pkg::REG_STATUS) regs[a] = d;
      else if (a == cala_pkg::REG_STATUS) st = d[7:0];
   endtask

   // bus read, data checked in the cycle after the strobe
   task automatic rd(input logic [3:0] a);
      logic [15:0] e;
      e = (a < cala_pkg::REG_STATUS) ? regs[a] : (a == cala_pkg::REG_STATUS) ? {8'h00, st} : 16'h0000;
      reg_addr_i <= a;
      reg_re_i <= 1'b1;
      reg_we_i <= 1'b0;
      @(posedge clk_i);
      #1;
      chk(reg_rdata_o, e, "read");
   endtask

   // condition truth, indexed by condition code
   function automatic logic cond_ok(input logic [3:0] cc, input logic [7:0] s, input logic ce);
      logic [15:0] t;
      logic        lt;
      lt = s[1] ^ s[2];
      t = {1'b1, !ce, !s[6], s[6], !s[1], s[1], !s[3], s[3], !s[2], s[2], !lt, lt, lt | s[0], !(lt | s[0]), !s[0], s[0]};
      return t[cc];
   endfunction

   // assemble an instruction word of this type
   function automatic logic [23:0] mk(input logic d, input logic [4:0] f, input logic [1:0] y,
                                      input logic [2:0] x, input logic [3:0] c);
      return {cala_pkg::TYPE_COND_ALU, d, f, y, x, cala_pkg::PAD_ZERO, c};
   endfunction

   // issue one word, update the mirror, compare every result output
   task automatic run(input logic [23:0] w, input bit g);
      cala_pkg::cala_instr_s f;
      logic [16:0] sum;
      logic [15:0] x, y;
      logic        ok, pd, pe, v;
      f = w;
      pd = done_o;
      pe = executed_o;
      reg_we_i <= 1'b0;
      reg_re_i <= 1'b0;
      cala_seq_model_i.send(w);
      #1;
      ok = en_i && f.kind == cala_pkg::TYPE_COND_ALU && f.pad == cala_pkg::PAD_ZERO && cond_ok(f.cond, st, ce_expired_i)
           && (f.func == cala_pkg::FUNC_ADD_CARRY || f.func == cala_pkg::FUNC_ADD);
      if (ok) begin
         x = regs[f.xop];
         y = (f.yop == cala_pkg::YOP_ZERO) ? 16'h0000 : regs[4'h8 + {2'b00, f.yop}];
         sum = {1'b0, x} + {1'b0, y} + {16'h0000, f.func == cala_pkg::FUNC_ADD_CARRY && st[3]};
         v = (x[15] == y[15]) && (sum[15] != x[15]);
         regs[f.dest_fb ? 10 : 2] = sum[15:0];
         st = {st[7:4], sum[16], v, sum[15], sum[15:0] == 16'h0000};
      end
      chk({15'h0000, done_o}, {15'h0000, en_i ? 1'b1 : pd}, "done");
      chk({15'h0000, executed_o}, {15'h0000, en_i ? ok : pe}, "executed");
      chk(result_o, regs[2], "result");
      chk(feedback_o, regs[10], "feedback");
      chk({8'h00, status_o}, {8'h00, st}, "status");
      if (g) cala_seq_model_i.idle();
   endtask

   // reset, register map, corner sums, then random traffic
   initial begin
      i = $urandom(32'h81C7EE02);
      st = 8'h00;
      gap = 1'b1;
      repeat (20) @(posedge clk_i);
      rst_b_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      for (i = 0; i < 12; i++) wr(i[3:0], 16'($urandom));
      for (i = 0; i < 16; i++) rd(i[3:0]);
      wr(cala_pkg::REG_X0, 16'h7FFF);
      wr(cala_pkg::REG_Y0, 16'h0001);
      run(mk(1'b0, cala_pkg::FUNC_ADD, cala_pkg::YOP_Y0, 3'h0, cala_pkg::CC_ALWAYS), 1'b1);
      wr(cala_pkg::REG_X0, 16'hFFFF);
      run(mk(1'b1, cala_pkg::FUNC_ADD, cala_pkg::YOP_Y0, 3'h0, cala_pkg::CC_ALWAYS), 1'b0);
      run(mk(1'b0, cala_pkg::FUNC_ADD_CARRY, cala_pkg::YOP_ZERO, 3'h0, cala_pkg::CC_CARRY), 1'b1);
      for (i = 0; i < 400; i++) begin
         do_wr = gap && ($urandom_range(0, 2) == 0);
         do_rd = gap && ($urandom_range(0, 3) == 0);
         // bus traffic only with the enable up, the enable redrawn at random before each issue
         if (do_wr || do_rd) en_i <= 1'b1;
         if (do_wr) wr(4'($urandom_range(0, 15)), 16'($urandom));
         if (do_rd) rd(4'($urandom_range(0, 15)));
         gap = ($urandom_range(0, 2) != 0) || i == 399;
         en_i <= ($urandom_range(0, 9) != 0);
         ce_expired_i <= 1'($urandom_range(0, 1));
         run({($urandom_range(0, 7) == 0) ? 5'($urandom) : cala_pkg::TYPE_COND_ALU, 1'($urandom),
              ($urandom_range(0, 5) == 0) ? 5'($urandom) : ($urandom_range(0, 1) ? cala_pkg::FUNC_ADD
              : cala_pkg::FUNC_ADD_CARRY), 2'($urandom), 3'($urandom),
              ($urandom_range(0, 7) == 0) ? 4'($urandom) : cala_pkg::PAD_ZERO, 4'($urandom)}, gap);
      end
      final_report();
   end

   // watchdog far beyond the expected run length
   initial begin
      repeat (20000) @(posedge clk_i);
      failures++;
      final_report();
   end
endmodule
